/* File: verilog/rtd_pkg.sv */
// package: constants for the descriptor table lookup block
package rtd_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   // descriptor table span in shared RAM
   localparam logic [15:0] TABLE_BASE = 16'h0200;
   localparam logic [15:0] TABLE_LAST = 16'h03ff;
   localparam int NUM_BLOCKS = 128;
   localparam int WORDS_PER_BLOCK = 4;
   // quadrant offsets in words
   localparam logic [15:0] QOFS_RX_SA = 16'h0000;
   localparam logic [15:0] QOFS_TX_SA = 16'h0080;
   localparam logic [15:0] QOFS_RX_MC = 16'h0100;
   localparam logic [15:0] QOFS_TX_MC = 16'h0180;
   localparam logic [4:0] SA_MODE_LO = 5'h00;
   localparam logic [4:0] SA_MODE_HI = 5'h1f;
   localparam logic [4:0] MC_NODATA_LIMIT = 5'h0f;
   localparam int MAX_DATA_WORDS = 32;
   // command word fields
   localparam int CMD_TR_BIT = 10;
   localparam int CMD_SA_LSB = 5;
   localparam int CMD_RT_LSB = 11;
   localparam logic [4:0] RT_BROADCAST_SEEN_FLAG = 5'h1f;
   // control word fields
   localparam int CW_INDEX_ZERO_IRQ_ENABLE = 15;
   localparam int CW_MKBUSY = 12;
   localparam int CW_ACC = 11;
   localparam int CW_BUFB = 10;
   localparam int CW_BROADCAST_SEEN_FLAG = 9;
   localparam int CW_METH_LSB = 0;
   localparam int CW_IDX_LSB = 8;
   localparam logic [15:0] CW_RESET = 16'h0000;
   localparam logic [15:0] CW_HOST_ANY = 16'hf008;
   localparam logic [15:0] CW_HOST_STOP = 16'h00f7;
   localparam logic [15:0] CW_SOFTWARE_RESET_COMMAND_CLR = 16'h0e00;
   // buffer methods, control word bits 1:0
   localparam logic [1:0] METH_INDEXED = 2'h0;
   localparam logic [1:0] METH_PINGPONG = 2'h1;
   localparam logic [1:0] METH_CIRC1 = 2'h2;
   localparam logic [1:0] METH_CIRC2 = 2'h3;
   // host register indices (word addresses below the table)
   localparam logic [15:0] REG_CFG = 16'h0000;
   localparam logic [15:0] REG_CUR_CW = 16'h0001;
   localparam logic [15:0] REG_STATUS = 16'h0002;
   localparam int CFG_EXEC = 0;
   localparam int CFG_INDEX_ZERO_IRQ_ENABLE_EN = 1;
   localparam int CFG_BCST_DIS = 2;
endpackage

/* File: verilog/rtd_lookup.sv */
// descriptor table lookup and control word maintenance
`timescale 1ns/100ps
//
// Contract
// - table occupies shared RAM words 0x0200 through 0x03FF
// - 128 blocks of four words, four quadrants, control word first
// - non-mode command, T/R 0: receive subaddress quadrant
// - non-mode command, T/R 1: transmit subaddress quadrant
// - subaddress commands carry one to 32 data words
// - subaddress 0 and 31 are mode commands; padding blocks unused
// - mode commands pick receive or transmit mode quadrant by T/R
// - mode quadrants index by mode code, others by subaddress
// - defined transmit mode codes below 0x0F send status only
// - last valid command control word address readable
// - descriptor words interpreted per selected buffer method
// - indexed: preset count of messages, interrupt when done
// - ping-pong: messages alternate between two buffers
// - circular 1: info, time tag and data share one buffer
// - circular 2: data and info in separate buffers, by count
// - control word updated after each command per method
// - bits 8-11 device-written only, updated while executing
// - master reset clears word; software reset clears 11,10,9
// - read of a control word clears accessed flag
// - interrupt on index reaching zero when both enables set
// - index-zero interrupt sets pending and asserts message output
// - buffer selector toggles only after error-free message
// - accessed flag set on message completion
// - broadcast flag set on valid broadcast receive unless disabled
module rtd_lookup #(
   parameter int BLOCKS = rtd_pkg::NUM_BLOCKS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic software_reset_command,
   input wire logic cmdValid,
   input wire logic [rtd_pkg::DATA_W-1:0] cmdWord,
   input wire logic msgDone,
   input wire logic msgError,
   input wire logic msgIllegal,
   input wire logic [rtd_pkg::ADDR_W-1:0] regAddr,
   input wire logic [rtd_pkg::DATA_W-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [rtd_pkg::DATA_W-1:0] regRdData,
   output logic [rtd_pkg::ADDR_W-1:0] cwAddr,
   output logic [1:0] bufMethod,
   output logic useBufferB,
   output logic statusOnly,
   output logic isModeCmd,
   output logic message_irq_output
);
   import rtd_pkg::*;

   initial begin
      if (BLOCKS != NUM_BLOCKS)
         $error("descriptor table must hold 128 blocks");
   end

   logic [15:0] cwMem [BLOCKS];
   // message counts kept apart so the host can preset them
   logic [3:0] idxMem [BLOCKS];
   logic bcastCmdHeld;
   logic [15:0] cfg;
   logic pendingIrq;
   logic cmdActive;
   logic [6:0] curBlock;
   logic [6:0] next_block;
   logic [4:0] saField;
   logic [4:0] modeCode;
   logic tr;
   logic modeCmd;
   logic bcastCmd;
   logic [15:0] curCw;
   logic [3:0] idxNow;
   logic [3:0] next_idx;
   logic idxHitZero;
   logic cleanMsg;
   logic tableHit;
   logic [6:0] tableBlock;
   logic [1:0] tableWord;
   logic [15:0] tableOfs;
   logic terminalExec;

   assign terminalExec = cfg[CFG_EXEC];
   assign saField = cmdWord[CMD_SA_LSB +: 5];
   assign modeCode = cmdWord[4:0];
   assign tr = cmdWord[CMD_TR_BIT];
   assign modeCmd = (saField == SA_MODE_LO) || (saField == SA_MODE_HI);
   assign bcastCmd = (cmdWord[CMD_RT_LSB +: 5] == RT_BROADCAST_SEEN_FLAG) && !tr
      && !cfg[CFG_BCST_DIS];

   // block number: quadrant in bits 6:5, index in bits 4:0
   always_comb begin
      unique case ({modeCmd, tr})
         2'b00: next_block = {2'h0, saField};
         2'b01: next_block = {2'h1, saField};
         2'b10: next_block = {2'h2, modeCode};
         2'b11: next_block = {2'h3, modeCode};
      endcase
   end

   // host side decode of the table span
   assign tableOfs = regAddr - TABLE_BASE;
   assign tableHit = (regAddr >= TABLE_BASE) && (regAddr <= TABLE_LAST);
   assign tableBlock = tableOfs[8:2];
   assign tableWord = tableOfs[1:0];

   assign curCw = cwMem[curBlock];
   assign idxNow = idxMem[curBlock];
   assign cleanMsg = !msgError && !msgIllegal && !curCw[CW_MKBUSY];
   // count lives in descriptor word 1, so device bits of the
   // control word stay free for the status flags
   assign idxHitZero = cmdActive && msgDone && cleanMsg
      && (curCw[1:0] != METH_PINGPONG) && (idxNow == 4'h1);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg <= 16'h0000;
      end else if (regWrite && regAddr == REG_CFG) begin
         cfg <= regWrData;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cmdActive <= 1'b0;
         curBlock <= 7'h00;
         cwAddr <= TABLE_BASE;
         isModeCmd <= 1'b0;
         statusOnly <= 1'b0;
      end else if (cmdValid && terminalExec) begin
         cmdActive <= 1'b1;
         curBlock <= next_block;
         cwAddr <= TABLE_BASE + {7'h00, next_block, 2'h0};
         isModeCmd <= modeCmd;
         statusOnly <= modeCmd && tr && (modeCode < MC_NODATA_LIMIT);
      end else if (msgDone) begin
         cmdActive <= 1'b0;
      end
   end

   // method and buffer choice for the data path, taken combinationally from the current control word
   assign bufMethod = curCw[1:0];
   assign useBufferB = (curCw[1:0] == METH_PINGPONG) && curCw[CW_BUFB];

   always_comb begin
      next_idx = idxNow;
      if (idxNow != 4'h0)
         next_idx = idxNow - 4'h1;
   end

   // control word storage: one writer process for all sources
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < BLOCKS; i++)
            cwMem[i] <= CW_RESET;
      end else begin
         if (software_reset_command) begin
            for (int i = 0; i < BLOCKS; i++)
               cwMem[i] <= cwMem[i] & ~CW_SOFTWARE_RESET_COMMAND_CLR;
         end else begin
            if (regWrite && tableHit && tableWord == 2'h0) begin
               // device-owned bits never come from the host
               cwMem[tableBlock] <= (cwMem[tableBlock]
                  & ~(terminalExec ? CW_HOST_ANY : CW_HOST_ANY | CW_HOST_STOP))
                  | (regWrData
                  & (terminalExec ? CW_HOST_ANY : CW_HOST_ANY | CW_HOST_STOP));
            end
            if (regRead && tableHit && tableWord == 2'h0)
               cwMem[tableBlock][CW_ACC] <= 1'b0;
            // device update wins over a same-cycle host access
            if (cmdActive && msgDone && terminalExec) begin
               cwMem[curBlock][CW_ACC] <= 1'b1;
               if (curCw[1:0] == METH_PINGPONG && cleanMsg)
                  cwMem[curBlock][CW_BUFB] <= ~curCw[CW_BUFB];
               if (bcastCmdHeld)
                  cwMem[curBlock][CW_BROADCAST_SEEN_FLAG] <= 1'b1;
            end
         end
      end
   end

   // message count per block; device decrement wins over a host preset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < BLOCKS; i++)
            idxMem[i] <= 4'h0;
      end else begin
         if (regWrite && tableHit && tableWord == 2'h1)
            idxMem[tableBlock] <= regWrData[3:0];
         if (cmdActive && msgDone && terminalExec && cleanMsg
               && curCw[1:0] != METH_PINGPONG)
            idxMem[curBlock] <= next_idx;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n)
         bcastCmdHeld <= 1'b0;
      else if (cmdValid && terminalExec)
         bcastCmdHeld <= bcastCmd && !modeCmd;
   end

   // pending index-zero interrupt; new event wins over clear
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pendingIrq <= 1'b0;
      end else if (idxHitZero && curCw[CW_INDEX_ZERO_IRQ_ENABLE] && cfg[CFG_INDEX_ZERO_IRQ_ENABLE_EN]) begin
         pendingIrq <= 1'b1;
      end else if (regRead && regAddr == REG_STATUS) begin
         pendingIrq <= 1'b0;
      end
   end
   assign message_irq_output = pendingIrq;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData <= 16'h0000;
      end else if (regRead) begin
         if (tableHit && tableWord == 2'h0)
            regRdData <= cwMem[tableBlock];
         else if (tableHit && tableWord == 2'h1)
            regRdData <= {12'h000, idxMem[tableBlock]};
         else if (regAddr == REG_CFG)
            regRdData <= cfg;
         else if (regAddr == REG_CUR_CW)
            regRdData <= cwAddr;
         else if (regAddr == REG_STATUS)
            regRdData <= {14'h0000, cmdActive, pendingIrq};
         else
            regRdData <= 16'h0000;
      end else begin
         regRdData <= 16'h0000;
      end
   end

   property p_addr;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && terminalExec |=> cwAddr[1:0] == 2'h0
      && cwAddr >= TABLE_BASE && cwAddr <= TABLE_LAST;
   endproperty
   a_addr: assert property (p_addr) else $error("address");
   property p_mode_q;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && terminalExec && modeCmd |=> cwAddr[8] == 1'b1;
   endproperty
   a_mode_q: assert property (p_mode_q) else $error("mode quadrant");
   property p_sa_q;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && terminalExec && !modeCmd |=> cwAddr[8] == 1'b0
      && cwAddr[7] == $past(tr);
   endproperty
   a_sa_q: assert property (p_sa_q) else $error("subaddress quadrant");
   property p_irq;
      @(posedge clk) disable iff (!reset_n)
      idxHitZero && curCw[CW_INDEX_ZERO_IRQ_ENABLE] && cfg[CFG_INDEX_ZERO_IRQ_ENABLE_EN]
      |=> message_irq_output;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_irq_cause;
      @(posedge clk) disable iff (!reset_n)
      $rose(message_irq_output) |-> $past(idxHitZero);
   endproperty
   a_irq_cause: assert property (p_irq_cause) else $error("spurious irq");
   property p_rd_data;
      @(posedge clk) disable iff (!reset_n)
      !regRead |=> regRdData == 16'h0000;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data idle");
   property p_status;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && terminalExec && modeCmd && tr && modeCode < MC_NODATA_LIMIT
      |=> statusOnly;
   endproperty
   a_status: assert property (p_status) else $error("status only");
   property p_cur;
      @(posedge clk) disable iff (!reset_n)
      regRead && regAddr == REG_CUR_CW |=> regRdData == $past(cwAddr);
   endproperty
   a_cur: assert property (p_cur) else $error("current cw address");

   // update checks hold the block fixed by excluding a new command
   property p_idx_dec;
      @(posedge clk) disable iff (!reset_n)
      cmdActive && msgDone && terminalExec && cleanMsg && !cmdValid
      && curCw[1:0] != METH_PINGPONG && idxNow != 4'h0
      |=> idxNow == $past(idxNow) - 4'h1;
   endproperty
   a_idx_dec: assert property (p_idx_dec) else $error("count");
   property p_bufb_keep;
      @(posedge clk) disable iff (!reset_n)
      cmdActive && msgDone && !cleanMsg && !software_reset_command
      && !cmdValid |=> curCw[CW_BUFB] == $past(curCw[CW_BUFB]);
   endproperty
   a_bufb_keep: assert property (p_bufb_keep) else $error("bufb");
   property p_acc_set;
      @(posedge clk) disable iff (!reset_n)
      cmdActive && msgDone && terminalExec && !software_reset_command
      && !cmdValid |=> curCw[CW_ACC];
   endproperty
   a_acc_set: assert property (p_acc_set) else $error("accessed");
   property p_software_reset_command;
      @(posedge clk) disable iff (!reset_n)
      software_reset_command && !cmdValid |=> (curCw & CW_SOFTWARE_RESET_COMMAND_CLR) == 16'h0;
   endproperty
   a_software_reset_command: assert property (p_software_reset_command) else $error("software reset");
   property p_no_exec;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && !terminalExec |=> $stable(cwAddr);
   endproperty
   a_no_exec: assert property (p_no_exec) else $error("stopped");
   // host writes never reach the device-owned nibble
   property p_host_dev;
      @(posedge clk) disable iff (!reset_n)
      regWrite && tableHit && tableWord == 2'h0 && tableBlock == curBlock
      && !(cmdActive && msgDone) && !software_reset_command && !cmdValid
      |=> ((curCw ^ $past(curCw)) & ~(CW_HOST_ANY | CW_HOST_STOP)) == 16'h0;
   endproperty
   a_host_dev: assert property (p_host_dev) else $error("host bits");
   property p_rd_clr;
      @(posedge clk) disable iff (!reset_n)
      regRead && tableHit && tableWord == 2'h0 && tableBlock == curBlock
      && !(cmdActive && msgDone && terminalExec) && !cmdValid
      |=> !curCw[CW_ACC];
   endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("read clear");
   property p_mc_index;
      @(posedge clk) disable iff (!reset_n)
      cmdValid && terminalExec && modeCmd |=> cwAddr[6:2] == $past(modeCode);
   endproperty
   a_mc_index: assert property (p_mc_index) else $error("mode index");
   c_mode: cover property (@(posedge clk) cmdValid && terminalExec && modeCmd);
   c_irq: cover property (@(posedge clk) $rose(message_irq_output));
   c_pp: cover property (@(posedge clk) msgDone && useBufferB);
   c_idx_zero: cover property (@(posedge clk) idxHitZero);
   c_software_reset_command: cover property (@(posedge clk) software_reset_command);
endmodule

/* File: test/rtd_bc_model.sv */
// bus controller model issuing command words and completions
`timescale 1ns/100ps
module rtd_bc_model (
   input wire logic clk,
   output logic cmdValid,
   output logic [rtd_pkg::DATA_W-1:0] cmdWord,
   output logic msgDone,
   output logic msgError,
   output logic msgIllegal
);
   initial begin
      cmdValid = 1'b0;
      cmdWord = 16'h5a5a;
      msgDone = 1'b0;
      msgError = 1'b1;
      msgIllegal = 1'b1;
   end
   // gap is 0 to 3 idle cycles in the bench, standing for the data words on the bus
   task automatic message(input logic [15:0] w, input logic err, ill,
         input int gap);
      cmdValid <= 1'b1;
      cmdWord <= w;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdWord <= ~w; // released word must not look valid
      repeat (gap) @(posedge clk);
      msgDone <= 1'b1;
      msgError <= err;
      msgIllegal <= ill;
      @(posedge clk);
      msgDone <= 1'b0;
      msgError <= ~err;
      msgIllegal <= ~ill;
      @(posedge clk);
   endtask
endmodule

/* File: test/tb_rtd_lookup.sv */
// self-checking bench for the descriptor table lookup block
`timescale 1ns/100ps
module tb_rtd_lookup;
   import rtd_pkg::*;
   logic clk, reset_n, software_reset_command, regWrite, regRead;
   logic cmdValid, msgDone, msgError, msgIllegal, useBufferB, statusOnly;
   logic isModeCmd, message_irq_output;
   logic [15:0] cmdWord, regAddr, regWrData, regRdData, cwAddr, w;
   logic [1:0] bufMethod;
   logic rdPend = 1'b0;
   logic [31:0] expQ[$];
   logic [31:0] seed = 32'hc9307d15;
   int failures = 0;
   int numChecks = 0;
   rtd_lookup rtd_lookup_i (.clk(clk), .reset_n(reset_n),
      .software_reset_command(software_reset_command),
      .cmdValid(cmdValid), .cmdWord(cmdWord), .msgDone(msgDone),
      .msgError(msgError), .msgIllegal(msgIllegal), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .cwAddr(cwAddr), .bufMethod(bufMethod),
      .useBufferB(useBufferB), .statusOnly(statusOnly),
      .isModeCmd(isModeCmd), .message_irq_output(message_irq_output));
   rtd_bc_model rtd_bc_model_i (.clk(clk), .cmdValid(cmdValid),
      .cmdWord(cmdWord), .msgDone(msgDone), .msgError(msgError),
      .msgIllegal(msgIllegal));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic isMode(input logic [15:0] c);
      return c[9:5] == SA_MODE_LO || c[9:5] == SA_MODE_HI;
   endfunction
   function automatic logic [15:0] cwOf(input logic [15:0] c);
      logic [15:0] q;
      q = isMode(c) ? (c[10] ? QOFS_TX_MC : QOFS_RX_MC)
         : (c[10] ? QOFS_TX_SA : QOFS_RX_SA);
      return TABLE_BASE + q + {9'h000, isMode(c) ? c[4:0] : c[9:5], 2'h0};
   endfunction
   // read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rdPend) begin
         numChecks++;
         if (expQ.size() == 0 ||
               (regRdData & expQ[0][15:0]) !== expQ[0][31:16]) begin
            failures++;
            $display("Error %0t: read data %h", $time, regRdData);
         end
         if (expQ.size() != 0) void'(expQ.pop_front());
      end
      rdPend <= regRead;
   end
   task automatic wr(input logic [15:0] a, d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      regRead <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, e, m = 16'hffff);
      regAddr <= a;
      regRead <= 1'b1;
      regWrite <= 1'b0;
      expQ.push_back({e & m, m});
      @(posedge clk);
   endtask
   task automatic idle(input int n);
      regRead <= 1'b0;
      regWrite <= 1'b0;
      repeat (n) @(posedge clk);
   endtask
   task automatic msg(input logic [15:0] c, input logic err, ill,
         input int gap);
      idle(0);
      rtd_bc_model_i.message(c, err, ill, gap);
      idle(1);
   endtask
   task automatic chk(input logic got, exp, input string what);
      numChecks++;
      if (got !== exp) begin
         failures++;
         $display("Error %0t: %s", $time, what);
      end
   endtask
   task automatic close_out;
      $display("checks %0d failures %0d", numChecks, failures);
      if (failures == 0 && numChecks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // whole run is well under a thousand cycles
   initial begin
      #400000;
      failures++;
      $display("Error %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      reset_n = 1'b0;
      software_reset_command = 1'b0;
      regAddr = 16'h0000;
      regWrData = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rd(REG_CFG, 16'h0000);
      rd(REG_CUR_CW, TABLE_BASE);
      rd(16'h0214, CW_RESET);
      rd(16'h0100, 16'h0000);
      msg(16'h0862, 1'b0, 1'b0, 2);
      rd(REG_CUR_CW, TABLE_BASE);
      rd(16'h020c, CW_RESET);
      $display("test reset and stopped done");
      wr(16'h0214, 16'hffff);
      rd(16'h0214, 16'hf0ff);
      wr(16'h020c, {14'h0000, METH_PINGPONG});
      wr(REG_CFG, 16'h0003);
      wr(16'h0214, 16'h0000);
      rd(16'h0214, 16'h00f7);
      $display("test host masking done");
      msg(16'h0862, 1'b0, 1'b0, 1);
      chk(useBufferB, 1'b1, "buffer select after good message");
      rd(REG_CUR_CW, 16'h020c);
      rd(16'h020c, 16'h0c01);
      rd(16'h020c, 16'h0401);
      msg(16'h0862, 1'b1, 1'b0, 3);
      rd(16'h020c, 16'h0400, 16'h0400);
      msg(16'h0862, 1'b0, 1'b1, 0);
      rd(16'h020c, 16'h0400, 16'h0400);
      msg(16'hf862, 1'b0, 1'b0, 2);
      rd(16'h020c, 16'h0200, 16'h0600);
      msg(16'h0862, 1'b0, 1'b0, 1);
      software_reset_command <= 1'b1;
      @(posedge clk);
      software_reset_command <= 1'b0;
      @(posedge clk);
      rd(16'h020c, 16'h0001);
      $display("test ping-pong done");
      msg(16'h0c02, 1'b0, 1'b0, 1);
      chk(isModeCmd, 1'b1, "mode flag");
      chk(statusOnly, 1'b1, "status only");
      rd(REG_CUR_CW, 16'h0388);
      wr(16'h0215, 16'h0001);
      wr(16'h0214, 16'h80f7);
      rd(16'h0215, 16'h0001);
      msg(16'h08a0, 1'b0, 1'b0, 2);
      chk(message_irq_output, 1'b1, "index zero irq");
      chk(bufMethod == METH_CIRC2, 1'b1, "buffer method");
      rd(16'h0215, 16'h0000);
      rd(REG_STATUS, 16'h0001);
      idle(1);
      chk(message_irq_output, 1'b0, "irq cleared");
      $display("test index interrupt done");
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         w = seed[15:0];
         if (w[15:11] == RT_BROADCAST_SEEN_FLAG) w[15] = 1'b0;
         msg(w, seed[16], 1'b0, int'(seed[18:17]));
         chk(isModeCmd, isMode(w), "mode flag");
         rd(REG_CUR_CW, cwOf(w));
      end
      $display("test lookup done");
      idle(2);
      close_out();
   end
endmodule
